// >>> acbx_pkg.sv
// acbx_pkg: constants shared by the vendor ata command block executor and its fifo
// assumes one 100 MHz core clock and a simple register-access port toward the drive
package acbx_pkg;
    localparam logic [7:0] SUBCMD_ATA      = 8'h24;
    // action control byte fields
    localparam int         ACT_IDENTIFY    = 7;
    localparam int         ACT_UDMA        = 6;
    localparam int         ACT_DEVSRC      = 5;
    localparam int         ACT_DERR_CONT   = 4;
    localparam int         ACT_PERR_CONT   = 3;
    localparam int         ACT_POLL_SKIP   = 2;
    localparam int         ACT_SEL_AFTER   = 1;
    localparam int         ACT_READBACK    = 0;
    // drive bit within the device/head byte
    localparam int         DEV_BIT         = 4;
    localparam int         BSY_BIT         = 7;
    localparam int         ERR_BIT         = 0;
    localparam int         IDX_DEVHEAD     = 6;
    localparam int         IDX_COMMAND     = 7;
    localparam logic [3:0] RB_LEN          = 4'h8;
    localparam int         FIFO_DEPTH      = 16;
    localparam int         FIFO_WIDTH      = 8;
    localparam logic [7:0] RESET_BYTE      = 8'h00;
    // task-file addresses per mask bit
    localparam logic [9:0] TF_ADDR [8] = '{10'h3f6, 10'h1f1, 10'h1f2, 10'h1f3,
                                          10'h1f4, 10'h1f5, 10'h1f6, 10'h1f7};
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_POLL  = 7'h02,
        ST_WAIT  = 7'h04,
        ST_ACC   = 7'h08,
        ST_DATA  = 7'h10,
        ST_PUSH  = 7'h20,
        ST_DONE  = 7'h40
    } acbx_state_t;
endpackage : acbx_pkg

// >>> acbx_fifo.sv
// acbx_fifo: flip-flop fifo with valid/ready on both sides
// assumes both sides on clk_sys
`timescale 1ns/1ps
module acbx_fifo
    import acbx_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wrPtr_ff;
    logic [AW-1:0]    rdPtr_ff;
    logic [AW:0]      count_ff;
    logic             doWr;
    logic             doRd;

    assign inReady  = (count_ff != DEPTH[AW:0]);
    assign outValid = (count_ff != '0);
    assign outData  = mem_ff[rdPtr_ff];
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;

    // storage writes
    always_ff @(posedge clk_sys) begin
        if (doWr) begin
            mem_ff[wrPtr_ff] <= inData;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (doWr) begin
                wrPtr_ff <= wrPtr_ff + 1'b1;
            end
            if (doRd) begin
                rdPtr_ff <= rdPtr_ff + 1'b1;
            end
            if (doWr && !doRd) begin
                count_ff <= count_ff + 1'b1;
            end else if (doRd && !doWr) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

    chk_fifo_no_overflow: assert property (@(posedge clk_sys) disable iff (!rstn)
        count_ff <= DEPTH) else $error("fifo count above depth");
endmodule : acbx_fifo

// >>> acbx_executor.sv
// acbx_executor: interprets the action control byte and register select mask of a
// vendor ata command block and sequences task-file accesses toward the drive
// assumes the command block arrives as a one-cycle strobe with all bytes parallel,
// and that the drive port answers each access with a one-cycle done pulse
`timescale 1ns/1ps
module acbx_executor
    import acbx_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // command block from the usb side
    input  wire logic        cmdValid,
    input  wire logic [7:0]  subcommandByte,
    input  wire logic [7:0]  actionControlByte,
    input  wire logic [7:0]  registerSelectMask,
    input  wire logic [63:0] taskFileWriteData,
    input  wire logic        lunDriveBit,
    output logic             cmdReady_ff,
    // readback stream toward the host
    output logic [7:0]       rbData_ff,
    output logic             rbValid_ff,
    input  wire logic        rbReady,
    // task-file access port toward the drive
    output logic             tfReq_ff,
    output logic             tfWrite_ff,
    output logic [9:0]       tfAddr_ff,
    output logic [7:0]       tfWrData_ff,
    input  wire logic [7:0]  tfRdData,
    input  wire logic        tfDone,
    // data phase control toward the transfer engine
    output logic             dataStart_ff,
    output logic             useUdma_ff,
    output logic             identifyData_ff,
    input  wire logic        dataDone,
    input  wire logic        devErrPin,
    input  wire logic        phaseErrPin,
    output logic             dataHalt_ff,
    output logic             busy_ff,
    output logic             cmdDone_ff
);
    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers for drive-side error lines
    logic [1:0] devErrSync_ff;
    logic [1:0] phaseErrSync_ff;

    // two-stage sync, logic reads only the second stage
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            devErrSync_ff   <= 2'h0;
            phaseErrSync_ff <= 2'h0;
        end else begin
            devErrSync_ff   <= {devErrSync_ff[0], devErrPin};
            phaseErrSync_ff <= {phaseErrSync_ff[0], phaseErrPin};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // latched command
    acbx_state_t state_ff;
    logic [7:0]  act_ff;
    logic [7:0]  mask_ff;
    logic [63:0] wrBytes_ff;
    logic [3:0]  idx_ff;
    logic        selDone_ff;
    logic [7:0]  rdByte;
    logic        fifoInReady;
    logic [7:0]  fifoOutData;
    logic        fifoOutValid;
    logic        fifoPop;
    logic        accept;
    logic        curSel;
    logic        skipCmdNow;
    logic [7:0]  devByte;

    assign accept  = cmdValid && cmdReady_ff && (subcommandByte == SUBCMD_ATA);
    assign curSel  = mask_ff[idx_ff[2:0]];
    // command already went out before the late selection pass, not again
    assign skipCmdNow = act_ff[ACT_SEL_AFTER] && selDone_ff
                        && (idx_ff[2:0] == IDX_COMMAND[2:0]);

    always_comb begin
        devByte = wrBytes_ff[8*IDX_DEVHEAD +: 8];
        if (!act_ff[ACT_DEVSRC]) begin
            devByte[DEV_BIT] = lunDriveBit;
        end
    end

    // latch command fields on acceptance
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            act_ff     <= 8'h00;
            mask_ff    <= 8'h00;
            wrBytes_ff <= 64'h0;
        end else if (accept) begin
            act_ff     <= actionControlByte;
            mask_ff    <= registerSelectMask;
            wrBytes_ff <= taskFileWriteData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_ff   <= ST_IDLE;
            idx_ff     <= 4'h0;
            selDone_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (accept) begin
                        idx_ff     <= 4'h0;
                        selDone_ff <= 1'b0;
                        state_ff   <= actionControlByte[ACT_POLL_SKIP] ? ST_ACC : ST_POLL;
                    end
                end
                ST_POLL: begin
                    state_ff <= ST_WAIT;
                end
                ST_WAIT: begin
                    // repeat alternate status read until busy clear
                    if (tfDone) begin
                        state_ff <= tfRdData[BSY_BIT] ? ST_POLL : ST_ACC;
                    end
                end
                ST_ACC: begin
                    if (idx_ff == RB_LEN) begin
                        if (act_ff[ACT_SEL_AFTER] && !selDone_ff && !act_ff[ACT_READBACK]
                            && mask_ff[IDX_DEVHEAD]) begin
                            selDone_ff <= 1'b1;
                            idx_ff     <= 4'(IDX_DEVHEAD);
                        end else begin
                            state_ff <= act_ff[ACT_READBACK] ? ST_DONE : ST_DATA;
                        end
                    end else if (tfReq_ff) begin
                        if (tfDone) begin
                            state_ff <= act_ff[ACT_READBACK] ? ST_PUSH : ST_ACC;
                            idx_ff   <= act_ff[ACT_READBACK] ? idx_ff : idx_ff + 4'h1;
                        end
                    end else if (act_ff[ACT_READBACK]) begin
                        // unselected registers still produce a zero byte
                        if (!curSel) begin
                            state_ff <= ST_PUSH;
                        end
                    end else if (!curSel || (skipCmdNow)
                                 || (act_ff[ACT_SEL_AFTER] && !selDone_ff
                                     && idx_ff[2:0] == IDX_DEVHEAD[2:0])) begin
                        idx_ff <= idx_ff + 4'h1;
                    end
                end
                ST_PUSH: begin
                    if (fifoInReady) begin
                        idx_ff   <= idx_ff + 4'h1;
                        state_ff <= ST_ACC;
                    end
                end
                ST_DATA: begin
                    // halt ends the data phase early
                    if (dataDone || dataHalt_ff) begin
                        state_ff <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_ff <= ST_IDLE;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // task-file access requests
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            tfReq_ff    <= 1'b0;
            tfWrite_ff  <= 1'b0;
            tfAddr_ff   <= 10'h0;
            tfWrData_ff <= 8'h00;
        end else if (state_ff == ST_POLL) begin
            tfReq_ff   <= 1'b1;
            tfWrite_ff <= 1'b0;
            tfAddr_ff  <= TF_ADDR[0];
        end else if (state_ff == ST_ACC && !tfReq_ff && idx_ff != RB_LEN && curSel
                     && (act_ff[ACT_READBACK] || !skipCmdNow)
                     && !(act_ff[ACT_SEL_AFTER] && !act_ff[ACT_READBACK] && !selDone_ff
                          && idx_ff[2:0] == IDX_DEVHEAD[2:0])) begin
            // access only selected registers at mapped addresses
            tfReq_ff    <= 1'b1;
            tfWrite_ff  <= !act_ff[ACT_READBACK];
            tfAddr_ff   <= TF_ADDR[idx_ff[2:0]];
            tfWrData_ff <= (idx_ff[2:0] == IDX_DEVHEAD[2:0]) ? devByte
                                                             : wrBytes_ff[8*idx_ff[2:0] +: 8];
        end else if (tfDone) begin
            tfReq_ff <= 1'b0;
        end
    end

    assign rdByte = curSel ? tfRdData : RESET_BYTE;
    logic [7:0] rbHold_ff;

    // capture read data when a readback access completes
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rbHold_ff <= 8'h00;
        end else if (state_ff == ST_ACC && act_ff[ACT_READBACK]) begin
            rbHold_ff <= (tfReq_ff && tfDone) ? rdByte : RESET_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // readback bytes leave in mask order through the fifo
    acbx_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .inData   (rbHold_ff),
        .inValid  (state_ff == ST_PUSH),
        .inReady  (fifoInReady),
        .outData  (fifoOutData),
        .outValid (fifoOutValid),
        .outReady (fifoPop)
    );

    assign fifoPop = fifoOutValid && (!rbValid_ff || rbReady);

    // output register stage for the readback stream
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rbValid_ff <= 1'b0;
            rbData_ff  <= 8'h00;
        end else if (fifoPop) begin
            rbValid_ff <= 1'b1;
            rbData_ff  <= fifoOutData;
        end else if (rbReady) begin
            rbValid_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // data phase control
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            dataStart_ff    <= 1'b0;
            useUdma_ff      <= 1'b0;
            identifyData_ff <= 1'b0;
            dataHalt_ff     <= 1'b0;
        end else begin
            dataStart_ff <= (state_ff == ST_ACC) && idx_ff == RB_LEN && !act_ff[ACT_READBACK]
                            && !(act_ff[ACT_SEL_AFTER] && !selDone_ff && mask_ff[IDX_DEVHEAD]);
            useUdma_ff      <= act_ff[ACT_UDMA];
            identifyData_ff <= act_ff[ACT_IDENTIFY];
            if (state_ff == ST_IDLE) begin
                dataHalt_ff <= 1'b0;
            end else if (state_ff == ST_DATA) begin
                // error halts unless continue bit set
                if ((devErrSync_ff[1] && !act_ff[ACT_DERR_CONT])
                    || (phaseErrSync_ff[1] && !act_ff[ACT_PERR_CONT])) begin
                    dataHalt_ff <= 1'b1;
                end
            end
        end
    end

    // handshake and status outputs
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cmdReady_ff <= 1'b0;
            busy_ff     <= 1'b0;
            cmdDone_ff  <= 1'b0;
        end else begin
            cmdReady_ff <= (state_ff == ST_IDLE) && !accept;
            busy_ff     <= (state_ff != ST_IDLE) || accept;
            cmdDone_ff  <= (state_ff == ST_DONE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    // skip unselected
    chk_sel_only_access: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(tfReq_ff) && state_ff != ST_WAIT |-> mask_ff[idx_ff[2:0]])
        else $error("unselected register accessed");
    chk_readback_no_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        tfReq_ff && act_ff[ACT_READBACK] |-> !tfWrite_ff)
        else $error("write during readback");
    chk_poll_skip: assert property (@(posedge clk_sys) disable iff (!rstn)
        accept && actionControlByte[ACT_POLL_SKIP] |=> state_ff == ST_ACC)
        else $error("poll not skipped");
    chk_dev_err_halt: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_ff == ST_DATA && devErrSync_ff[1] && !act_ff[ACT_DERR_CONT] |=> dataHalt_ff)
        else $error("device error did not halt");
    chk_phase_continue: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_ff == ST_DATA && !devErrSync_ff[1] && act_ff[ACT_PERR_CONT] && !dataHalt_ff
        |=> !dataHalt_ff)
        else $error("halted despite continue");
    chk_zero_unselected: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_ff == ST_ACC && act_ff[ACT_READBACK] && !tfReq_ff && !curSel
        && idx_ff != RB_LEN |=> rbHold_ff == 8'h00)
        else $error("unselected byte not zero");
    // device control address for bit zero
    chk_addr_map: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(tfReq_ff) && tfWrite_ff && idx_ff == 4'h0 |-> tfAddr_ff == 10'h3f6)
        else $error("bit zero address wrong");
    chk_udma_select: assert property (@(posedge clk_sys) disable iff (!rstn)
        dataStart_ff |-> useUdma_ff == act_ff[ACT_UDMA])
        else $error("udma select mismatch");
    // late selection pass never repeats the command write
    chk_cmd_once_late: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(tfReq_ff) && tfWrite_ff && act_ff[ACT_SEL_AFTER] && selDone_ff
        |-> tfAddr_ff != TF_ADDR[IDX_COMMAND])
        else $error("command written twice");
endmodule : acbx_executor

// >>> acbx_drive_model.sv
// acbx_drive_model: behavioural drive behind the executor's task-file access port
// assumes a request stands until the edge that carries tfDone, one request at a time
`timescale 1ns/1ps
module acbx_drive_model (
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       tfReq,
    input  wire logic [9:0] tfAddr,
    input  wire logic [2:0] latency,
    input  wire logic       busyArm,
    input  wire logic [3:0] busyReads,
    output logic      [7:0] tfRdData,
    output logic            tfDone
);
    logic [2:0] waitCnt;
    logic [3:0] busyLeft;
    logic [7:0] rdVal;
    logic [3:0] idx;
    ////////////////////////////////////////////////////////////
    // answer on the latency+1-th edge that sees the request; read data is only good with the done pulse
    always @(posedge clk_sys) begin
        idx = (tfAddr == 10'h3f6) ? 4'h7 : 4'(tfAddr - 10'h1f0);
        rdVal = 8'h50 + {4'h0, idx};
        tfDone <= 1'b0;
        tfRdData <= ~tfRdData;
        if (!rstn) begin
            waitCnt <= 3'h0;
            busyLeft <= 4'h0;
            tfRdData <= 8'h5a;
        end else if (busyArm) begin
            busyLeft <= busyReads;
        end else if (tfReq && !tfDone) begin
            waitCnt <= waitCnt + 3'h1;
            if (waitCnt == latency) begin
                waitCnt <= 3'h0;
                tfDone <= 1'b1;
                // alternate status shows busy until the armed reads run out
                if (tfAddr == 10'h3f6 && busyLeft != 4'h0) begin
                    rdVal = rdVal | 8'h80;
                    busyLeft <= busyLeft - 4'h1;
                end
                tfRdData <= rdVal;
            end
        end
    end
endmodule : acbx_drive_model

// >>> acbx_executor_tb.sv
// acbx_executor_tb: self-checking bench for the command block executor and its fifo
// assumes the bench acts as usb host and data engine, the drive model answers accesses
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module acbx_executor_tb
    import acbx_pkg::*;
;
    logic        clk_sys, rstn = 1'b0, cmdValid = 1'b0, lunDriveBit = 1'b0, rbReady = 1'b1;
    logic        dataDone = 1'b0, devErrPin = 1'b0, phaseErrPin = 1'b0, busyArm = 1'b0;
    logic        stallOn = 1'b0, holdRb = 1'b0;
    logic [7:0]  subcommandByte = 8'h00, actionControlByte = 8'h00, registerSelectMask = 8'h00;
    logic [63:0] taskFileWriteData = 64'h0;
    logic [2:0]  latency = 3'h0;
    logic [3:0]  busyReads = 4'h0;
    logic        cmdReady_ff, rbValid_ff, tfReq_ff, tfWrite_ff, tfDone, dataStart_ff;
    logic        useUdma_ff, identifyData_ff, dataHalt_ff, busy_ff, cmdDone_ff;
    logic [7:0]  rbData_ff, tfWrData_ff, tfRdData;
    logic [9:0]  tfAddr_ff;
    logic [9:0]  logA[$];
    logic [8:0]  logWD[$];
    logic [7:0]  rbQ[$];
    int          miscompares = 0;
    int          checks_done = 0;
    int          cyc = 0;
    ////////////////////////////////////////////////////////////
    acbx_executor u_acbx_executor (
        .clk_sys(clk_sys), .rstn(rstn), .cmdValid(cmdValid), .subcommandByte(subcommandByte),
        .actionControlByte(actionControlByte), .registerSelectMask(registerSelectMask),
        .taskFileWriteData(taskFileWriteData), .lunDriveBit(lunDriveBit),
        .cmdReady_ff(cmdReady_ff), .rbData_ff(rbData_ff), .rbValid_ff(rbValid_ff),
        .rbReady(rbReady), .tfReq_ff(tfReq_ff), .tfWrite_ff(tfWrite_ff), .tfAddr_ff(tfAddr_ff),
        .tfWrData_ff(tfWrData_ff), .tfRdData(tfRdData), .tfDone(tfDone),
        .dataStart_ff(dataStart_ff), .useUdma_ff(useUdma_ff), .identifyData_ff(identifyData_ff),
        .dataDone(dataDone), .devErrPin(devErrPin), .phaseErrPin(phaseErrPin),
        .dataHalt_ff(dataHalt_ff), .busy_ff(busy_ff), .cmdDone_ff(cmdDone_ff));
    acbx_drive_model u_acbx_drive_model (
        .clk_sys(clk_sys), .rstn(rstn), .tfReq(tfReq_ff), .tfAddr(tfAddr_ff), .latency(latency),
        .busyArm(busyArm), .busyReads(busyReads), .tfRdData(tfRdData), .tfDone(tfDone));
    ////////////////////////////////////////////////////////////
    // log finished accesses and accepted readback bytes
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (tfReq_ff && tfDone) begin
            logA.push_back(tfAddr_ff);
            logWD.push_back({tfWrite_ff, tfWrData_ff});
        end
        if (rbValid_ff && rbReady)
            rbQ.push_back(rbData_ff);
    end
    // host side accepts every third cycle while stalling
    always @(posedge clk_sys) #1 rbReady = !holdRb && (!stallOn || (cyc % 3 == 0));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////
    task automatic issue(input logic [7:0] sub, act, mask, input logic [63:0] wd);
        int n;
        for (n = 0; n < 300 && cmdReady_ff !== 1'b1; n++) @(posedge clk_sys) #1;
        logA.delete();
        logWD.delete();
        rbQ.delete();
        {subcommandByte, actionControlByte, registerSelectMask} = {sub, act, mask};
        taskFileWriteData = wd;
        cmdValid = 1'b1;
        @(posedge clk_sys) #1;
        cmdValid = 1'b0;
    endtask : issue
    task automatic wait_done();
        int n;
        for (n = 0; n < 3000 && cmdDone_ff !== 1'b1; n++) @(posedge clk_sys) #1;
        `CHK(n < 3000, 1'b1)
    endtask : wait_done
    task automatic wait_start();
        int n;
        for (n = 0; n < 300 && dataStart_ff !== 1'b1; n++) @(posedge clk_sys) #1;
        `CHK(n < 300, 1'b1)
    endtask : wait_start
    task automatic finish_data();
        repeat (3) @(posedge clk_sys);
        #1 dataDone = 1'b1;
        @(posedge clk_sys) #1;
        dataDone = 1'b0;
        wait_done();
    endtask : finish_data
    task automatic check_rb(input logic [7:0] mask);
        int n;
        for (n = 0; n < 300 && rbQ.size() < 8; n++) @(posedge clk_sys) #1;
        repeat (12) @(posedge clk_sys) #1;
        `CHK(rbQ.size(), 8)
        for (int i = 0; i < 8 && i < rbQ.size(); i++)
            `CHK(rbQ[i], mask[i] ? 8'h50 + (i == 0 ? 8'h7 : 8'(i)) : 8'h00)
    endtask : check_rb
    task automatic check_log(input logic [7:0] mask, input logic wr, input logic [63:0] wd);
        int k;
        k = 0;
        for (int i = 0; i < 8; i++)
            if (mask[i]) begin
                `CHK(logA[k], TF_ADDR[i])
                `CHK(logWD[k], {wr, wr ? wd[8*i +: 8] : logWD[k][7:0]})
                k++;
            end
        `CHK(logA.size(), k)
    endtask : check_log
    ////////////////////////////////////////////////////////////
    task automatic t_read_all();
        issue(8'h25, 8'h05, 8'hff, 64'h0);
        repeat (6) @(posedge clk_sys) #1;
        `CHK({busy_ff, tfReq_ff, logA.size() == 0}, 3'b001)
        issue(8'h24, 8'h05, 8'hff, 64'h0);
        wait_done();
        check_rb(8'hff);
        check_log(8'hff, 1'b0, 64'h0);
    endtask : t_read_all
    task automatic t_read_poll();
        {latency, stallOn, busyReads, busyArm} = {3'h3, 1'b1, 4'h2, 1'b1};
        @(posedge clk_sys) #1;
        busyArm = 1'b0;
        issue(8'h24, 8'h01, 8'ha4, 64'h0);
        wait_done();
        check_rb(8'ha4);
        for (int i = 0; i < 3; i++)
            `CHK(logA[i], 10'h3f6)
        logA = logA[3:$];
        logWD = logWD[3:$];
        check_log(8'ha4, 1'b0, 64'h0);
        {latency, stallOn} = {3'h0, 1'b0};
    endtask : t_read_poll
    task automatic t_write();
        lunDriveBit = 1'b1;
        issue(8'h24, 8'hc4, 8'hff, 64'h20e6_a5b4_c3d2_e1f0);
        wait_start();
        `CHK({useUdma_ff, identifyData_ff, busy_ff}, 3'b111)
        check_log(8'hff, 1'b1, 64'h20f6_a5b4_c3d2_e1f0);
        finish_data();
        `CHK({dataHalt_ff, rbQ.size() == 0}, 2'b01)
        lunDriveBit = 1'b0;
        issue(8'h24, 8'h26, 8'hc2, 64'hecf0_0000_0000_0300);
        wait_start();
        `CHK({useUdma_ff, identifyData_ff, logA.size() == 3}, 3'b001)
        `CHK({logA[0], logWD[0], logA[1], logWD[1]}, {10'h1f1, 9'h103, 10'h1f7, 9'h1ec})
        `CHK({logA[2], logWD[2]}, {10'h1f6, 9'h1f0})
        finish_data();
    endtask : t_write
    task automatic t_errors();
        logic seen;
        logic halt;
        for (int j = 0; j < 4; j++) begin
            issue(8'h24, j[0] ? (j[1] ? 8'h0c : 8'h14) : 8'h04, 8'h80, 64'h2000_0000_0000_0000);
            wait_start();
            {devErrPin, phaseErrPin, seen, halt} = {!j[1], j[1], 1'b0, 1'b0};
            repeat (12) begin
                @(posedge clk_sys) #1;
                seen |= cmdDone_ff;
                halt |= dataHalt_ff;
            end
            {devErrPin, phaseErrPin} = 2'b00;
            `CHK(halt, !j[0])
            `CHK(seen & j[0], 1'b0)
            if (seen !== 1'b1)
                finish_data();
        end
    endtask : t_errors
    task automatic t_fifo();
        holdRb = 1'b1;
        issue(8'h24, 8'h05, 8'hff, 64'h0);
        wait_done();
        repeat (5) @(posedge clk_sys) #1;
        `CHK({rbValid_ff, rbData_ff, rbQ.size() == 0}, {1'b1, 8'h57, 1'b1})
        holdRb = 1'b0;
        check_rb(8'hff);
    endtask : t_fifo
    task automatic end_sim();
        if (miscompares == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////
    // watchdog well past the few hundred cycles the tests need
    initial begin
        #200000;
        miscompares++;
        end_sim();
    end
    // reset for three cycles, then the scenarios in turn
    initial begin
        repeat (3) @(posedge clk_sys) #1;
        `CHK({cmdReady_ff, busy_ff, tfReq_ff, cmdDone_ff}, 4'h0)
        rstn = 1'b1;
        repeat (2) @(posedge clk_sys) #1;
        `CHK(cmdReady_ff, 1'b1)
        t_read_all();
        t_read_poll();
        t_write();
        t_errors();
        t_fifo();
        end_sim();
    end
endmodule : acbx_executor_tb
